// ### hw/cct_timer.sv
// eight-channel capture/compare timer with pulse accumulator
// What this block does
// RL1: 16-bit main counter clocked through a programmable prescaler.
// RL2: eight channels, each capture or compare, plus a pulse accumulator.
// RL3: capture channel records main count on the selected pin edge.
// RL4: compare channel drives its pin action when count matches its value.
// RL5: 16-bit accumulator counts events or gated time, chosen by software.
// RL6: event mode accumulator shares channel 7.
// RL7: channel 7 pin can also feed the pulse accumulator.
// RL8: 16-bit counter and channel values move as one word in one cycle.
// RL9: stop mode halts the clock, so the timer simply stands still.
// RL10: in freeze the counter runs unless the freeze-stop bit is set.
// RL11: in wait the main counter runs unless the wait-stop bit is set.
// RL12: counter runs while the run enable bit is one.
// RL13: one mode bit per channel, 0 capture, 1 compare, always read/write.
// RL14: eight pins, one per channel.
// RL15: register address is base plus offset.
// RL16: counter adds one per prescaled tick and wraps to zero.
// RL17: counter writes only act in test mode.
// RL18: force register reads zero; a one forces the compare action, no flag.
// RL19: channel 7 event overrides compare actions of channels 6 to 0.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cct_timer #(
   parameter int NCH = 8
) (
   input wire logic aclk, // bus clock, 40 MHz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic test_mode, // special test mode, enables counter writes
   input wire logic wait_mode, // system wait mode
   input wire logic freeze_mode, // debug freeze
   input wire logic [NCH-1:0] ioc_in, // channel pin levels
   output logic [NCH-1:0] ioc_out, // channel pin drive value
   output logic [NCH-1:0] ioc_oe // channel pin drive enable
);
   // ************
   // registers
   // ************
   logic [7:0] mode_sel, c7_mask, c7_data, scr1, tov, irq_en, scr2, ch_flags;
   logic [7:0] acc_ctl, pin_disc, pre_sel;
   logic [15:0] act_sel, edge_sel, main_count, acc_count;
   logic ovf_flag, acc_ovf, acc_edge_f;
   logic [15:0] ch_val [NCH]; //RL2
   logic [NCH-1:0] pin_q;

   function automatic logic [1:0] pick2(input logic [15:0] f, input int ch);
      pick2 = f[2*ch +: 2];
   endfunction

   function automatic logic apply_act(input logic [1:0] a, input logic cur);
      case (a)
         cct_pkg::ACT_TOGGLE: apply_act = ~cur;
         cct_pkg::ACT_CLEAR: apply_act = 1'b0;
         cct_pkg::ACT_SET: apply_act = 1'b1;
         default: apply_act = cur;
      endcase
   endfunction

   // ************
   // axi4-lite slave
   // ************
   logic aw_hold, w_hold;
   logic [5:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go, rd_go;
   logic [5:0] wr_idx, rd_idx;
   logic [31:0] next_rdata;
   logic rd_hit;

   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go = aw_hold & w_hold & ~s_axi_bvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign wr_idx = aw_idx;
   assign rd_idx = s_axi_araddr[7:2];

   function automatic logic mapped(input logic [31:0] a);
      logic [5:0] i;
      i = a[7:2];
      mapped = (a[31:8] == 24'h000000) && (i <= cct_pkg::IDX_ACC_LO || i == cct_pkg::IDX_PIN_DISC
               || i == cct_pkg::IDX_PRE_SEL);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_idx <= 6'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cct_pkg::AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_idx <= s_axi_awaddr[7:2];
            s_axi_bresp <= mapped(s_axi_awaddr) ? cct_pkg::AXI_OKAY : cct_pkg::AXI_SLVERR;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // write strobes per byte lane; a write to an unmapped index is dropped
   logic wr_b0, wr_b1;
   assign wr_b0 = wr_go && (s_axi_bresp == cct_pkg::AXI_OKAY) && w_strb[0];
   assign wr_b1 = wr_go && (s_axi_bresp == cct_pkg::AXI_OKAY) && w_strb[1];

   // ************
   // prescaler and main counter
   // ************
   logic run, tick, wrap, c7_match, c7_event;
   logic [7:0] pre_cnt, pre_top;
   assign run = scr1[cct_pkg::SCR1_RUN] //RL12
      && !(wait_mode && scr1[cct_pkg::SCR1_WAIT_STOP]) //RL11
      && !(freeze_mode && scr1[cct_pkg::SCR1_FRZ_STOP]); //RL10
   assign pre_top = scr1[cct_pkg::SCR1_PRECISE] ? pre_sel : 8'((9'h1 << scr2[2:0]) - 9'h1); //RL1
   assign tick = run && (pre_cnt >= pre_top); //RL9
   assign wrap = tick && (main_count == 16'hffff);

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= tick ? 8'h00 : 8'(pre_cnt + 8'h01);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_count <= 16'h0000;
      end else if (test_mode && wr_b0 && wr_idx == cct_pkg::IDX_CNT_HI) begin
         main_count <= {wr_b1 ? w_data[15:8] : main_count[15:8], w_data[7:0]}; //RL17 RL8
      end else if (test_mode && wr_b0 && wr_idx == cct_pkg::IDX_CNT_LO) begin
         main_count <= {main_count[15:8], w_data[7:0]}; //RL17
      end else if (tick) begin
         if (scr2[cct_pkg::SCR2_RST_ON_C7] && c7_match) begin
            main_count <= 16'h0000;
         end else begin
            main_count <= 16'(main_count + 16'h0001); //RL16
         end
      end
   end

   // ************
   // pin synchronisers
   // ************
   logic [NCH-1:0] sync1, sync2, sync3, pin_f, rise, fall;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_f <= '0;
      end else begin
         sync1 <= ioc_in;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_f <= (sync2 & sync3) | (pin_f & (sync2 | sync3));
      end
   end
   assign rise = sync2 & sync3 & ~pin_f;
   assign fall = ~sync2 & ~sync3 & pin_f;

   // ************
   // channels
   // ************
   logic [NCH-1:0] cap, match, force_ch, ch_set;
   assign force_ch = (wr_b0 && wr_idx == cct_pkg::IDX_FORCE) ? w_data[NCH-1:0] : '0; //RL18
   assign c7_match = tick && mode_sel[NCH-1] && (main_count == ch_val[NCH-1]);
   assign c7_event = c7_match || (wrap && tov[NCH-1]);

   // per-channel capture, match and flag set; each bit has one driver
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         logic [1:0] es;
         assign es = pick2(edge_sel, g);
         assign cap[g] = !mode_sel[g] && ((es == cct_pkg::EDG_RISE && rise[g]) //RL3
            || (es == cct_pkg::EDG_FALL && fall[g]) || (es == 2'h3 && (rise[g] | fall[g])));
         assign match[g] = tick && mode_sel[g] && (main_count == ch_val[g]); //RL4
         assign ch_set[g] = (cap[g] || match[g]) && !force_ch[g]; //RL18
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NCH; i++) begin
            ch_val[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap[i]) begin
               ch_val[i] <= main_count; //RL3
            end else if (wr_b0 && wr_idx == 6'(cct_pkg::IDX_CH_VAL + 6'(2 * i))) begin
               ch_val[i] <= {wr_b1 ? w_data[15:8] : ch_val[i][15:8], w_data[7:0]}; //RL8
            end else if (wr_b0 && wr_idx == 6'(cct_pkg::IDX_CH_VAL + 6'(2 * i + 1))) begin
               ch_val[i] <= {ch_val[i][15:8], w_data[7:0]};
            end
         end
      end
   end

   // pin drive: forced action first, then channel 7 override, match, overflow toggle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (force_ch[i] && mode_sel[i]) begin
               pin_q[i] <= apply_act(pick2(act_sel, i), pin_q[i]); //RL18
            end else if (c7_event && c7_mask[i]) begin
               pin_q[i] <= c7_data[i]; //RL19
            end else if (match[i]) begin
               pin_q[i] <= apply_act(pick2(act_sel, i), pin_q[i]); //RL4
            end else if (wrap && tov[i]) begin
               pin_q[i] <= ~pin_q[i];
            end
         end
      end
   end
   assign ioc_out = pin_q; //RL14
   assign ioc_oe = mode_sel & ~pin_disc; //RL13 RL14

   // ************
   // pulse accumulator on channel 7 pin
   // ************
   logic acc_on, acc_evt, acc_gate_end, acc_inc, gate_tick;
   logic [5:0] gate_cnt;
   assign acc_on = acc_ctl[cct_pkg::ACC_EN];
   assign gate_tick = (gate_cnt == 6'(cct_pkg::GATE_DIV - 1));
   assign acc_evt = acc_ctl[cct_pkg::ACC_EDGE] ? rise[NCH-1] : fall[NCH-1]; //RL6 RL7
   assign acc_gate_end = acc_ctl[cct_pkg::ACC_EDGE] ? rise[NCH-1] : fall[NCH-1];
   assign acc_inc = acc_on && (acc_ctl[cct_pkg::ACC_GATED]
      ? (gate_tick && (pin_f[NCH-1] ^ acc_ctl[cct_pkg::ACC_EDGE])) : acc_evt); //RL5

   always_ff @(posedge aclk) begin
      if (!aresetn || !acc_on) begin
         gate_cnt <= 6'h00;
      end else begin
         gate_cnt <= 6'(gate_cnt + 6'h01);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_count <= 16'h0000;
      end else if (wr_b0 && wr_idx == cct_pkg::IDX_ACC_HI) begin
         acc_count <= {wr_b1 ? w_data[15:8] : acc_count[15:8], w_data[7:0]};
      end else if (wr_b0 && wr_idx == cct_pkg::IDX_ACC_LO) begin
         acc_count <= {acc_count[15:8], w_data[7:0]};
      end else if (acc_inc) begin
         acc_count <= 16'(acc_count + 16'h0001); //RL5
      end
   end

   // ************
   // plain control registers and flags (set wins over write-one-clear)
   // ************
   logic flag_wr, ovf_wr, accf_wr;
   assign flag_wr = wr_b0 && wr_idx == cct_pkg::IDX_CH_FLAGS;
   assign ovf_wr = wr_b0 && wr_idx == cct_pkg::IDX_OVF_FLAG;
   assign accf_wr = wr_b0 && wr_idx == cct_pkg::IDX_ACC_FLAGS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ch_flags <= cct_pkg::RESET_BYTE;
         ovf_flag <= 1'b0;
         acc_ovf <= 1'b0;
         acc_edge_f <= 1'b0;
      end else begin
         ch_flags <= (ch_flags & ~(flag_wr ? w_data[7:0] : 8'h00)) | ch_set;
         ovf_flag <= (ovf_flag & ~(ovf_wr && w_data[cct_pkg::OVF_FLAG_BIT])) | wrap;
         acc_ovf <= (acc_ovf & ~(accf_wr && w_data[cct_pkg::ACC_OVF_BIT]))
            | (acc_inc && acc_count == 16'hffff);
         acc_edge_f <= (acc_edge_f & ~(accf_wr && w_data[cct_pkg::ACC_EDGE_BIT]))
            | (acc_on && (acc_ctl[cct_pkg::ACC_GATED] ? acc_gate_end : acc_evt));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_sel <= cct_pkg::RESET_BYTE;
         c7_mask <= cct_pkg::RESET_BYTE;
         c7_data <= cct_pkg::RESET_BYTE;
         scr1 <= cct_pkg::RESET_BYTE;
         tov <= cct_pkg::RESET_BYTE;
         act_sel <= 16'h0000;
         edge_sel <= 16'h0000;
         irq_en <= cct_pkg::RESET_BYTE;
         scr2 <= cct_pkg::RESET_BYTE;
         acc_ctl <= cct_pkg::RESET_BYTE;
         pin_disc <= cct_pkg::RESET_BYTE;
         pre_sel <= cct_pkg::RESET_BYTE;
      end else if (wr_b0) begin
         case (wr_idx)
            cct_pkg::IDX_MODE_SEL: mode_sel <= w_data[7:0]; //RL13 RL15
            cct_pkg::IDX_C7_MASK: c7_mask <= w_data[7:0];
            cct_pkg::IDX_C7_DATA: c7_data <= w_data[7:0];
            cct_pkg::IDX_SCR1: scr1 <= w_data[7:0] & cct_pkg::SCR1_MASK;
            cct_pkg::IDX_TOV: tov <= w_data[7:0];
            cct_pkg::IDX_ACT_UP: act_sel[15:8] <= w_data[7:0];
            cct_pkg::IDX_ACT_LO: act_sel[7:0] <= w_data[7:0];
            cct_pkg::IDX_EDGE_UP: edge_sel[15:8] <= w_data[7:0];
            cct_pkg::IDX_EDGE_LO: edge_sel[7:0] <= w_data[7:0];
            cct_pkg::IDX_IRQ_EN: irq_en <= w_data[7:0];
            cct_pkg::IDX_SCR2: scr2 <= w_data[7:0] & cct_pkg::SCR2_MASK;
            cct_pkg::IDX_ACC_CTL: acc_ctl <= w_data[7:0] & cct_pkg::ACC_CTL_MASK;
            cct_pkg::IDX_PIN_DISC: pin_disc <= w_data[7:0];
            cct_pkg::IDX_PRE_SEL: pre_sel <= w_data[7:0];
            default: ;
         endcase
      end
   end

   // ************
   // read path
   // ************
   always_comb begin
      next_rdata = 32'h00000000;
      rd_hit = mapped(s_axi_araddr);
      case (rd_idx)
         cct_pkg::IDX_MODE_SEL: next_rdata[7:0] = mode_sel; //RL13
         cct_pkg::IDX_FORCE: next_rdata = 32'h00000000; //RL18
         cct_pkg::IDX_C7_MASK: next_rdata[7:0] = c7_mask;
         cct_pkg::IDX_C7_DATA: next_rdata[7:0] = c7_data;
         cct_pkg::IDX_CNT_HI: next_rdata[15:0] = main_count; //RL8
         cct_pkg::IDX_CNT_LO: next_rdata[7:0] = main_count[7:0];
         cct_pkg::IDX_SCR1: next_rdata[7:0] = scr1;
         cct_pkg::IDX_TOV: next_rdata[7:0] = tov;
         cct_pkg::IDX_ACT_UP: next_rdata[7:0] = act_sel[15:8];
         cct_pkg::IDX_ACT_LO: next_rdata[7:0] = act_sel[7:0];
         cct_pkg::IDX_EDGE_UP: next_rdata[7:0] = edge_sel[15:8];
         cct_pkg::IDX_EDGE_LO: next_rdata[7:0] = edge_sel[7:0];
         cct_pkg::IDX_IRQ_EN: next_rdata[7:0] = irq_en;
         cct_pkg::IDX_SCR2: next_rdata[7:0] = scr2;
         cct_pkg::IDX_CH_FLAGS: next_rdata[7:0] = ch_flags;
         cct_pkg::IDX_OVF_FLAG: next_rdata[cct_pkg::OVF_FLAG_BIT] = ovf_flag;
         cct_pkg::IDX_ACC_CTL: next_rdata[7:0] = acc_ctl;
         cct_pkg::IDX_ACC_FLAGS: next_rdata[1:0] = {acc_ovf, acc_edge_f};
         cct_pkg::IDX_ACC_HI: next_rdata[15:0] = acc_count;
         cct_pkg::IDX_ACC_LO: next_rdata[7:0] = acc_count[7:0];
         cct_pkg::IDX_PIN_DISC: next_rdata[7:0] = pin_disc;
         cct_pkg::IDX_PRE_SEL: next_rdata[7:0] = pre_sel;
         default: begin
            if (rd_idx >= cct_pkg::IDX_CH_VAL && rd_idx <= cct_pkg::IDX_CH_VAL_END) begin
               next_rdata[15:0] = rd_idx[0] ? {8'h00, ch_val[rd_idx[3:1]][7:0]} : ch_val[rd_idx[3:1]];
            end
         end
      endcase
      if (!rd_hit) begin
         next_rdata = 32'h00000000;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= cct_pkg::AXI_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= rd_hit ? cct_pkg::AXI_OKAY : cct_pkg::AXI_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************
   // assertions
   // ************
   a_count_steps: assert property (@(posedge aclk) disable iff (!aresetn) //RL16
      tick && !test_mode && !(scr2[cct_pkg::SCR2_RST_ON_C7] && c7_match)
      |=> main_count == 16'($past(main_count) + 16'h0001))
      else $error("main count did not step on tick");
   a_count_holds: assert property (@(posedge aclk) disable iff (!aresetn) //RL12
      !scr1[cct_pkg::SCR1_RUN] && !test_mode |=> $stable(main_count))
      else $error("main count moved while disabled");
   a_wait_stop: assert property (@(posedge aclk) disable iff (!aresetn) //RL11
      wait_mode && scr1[cct_pkg::SCR1_WAIT_STOP] |-> !tick)
      else $error("tick in wait with wait stop set");
   a_freeze_stop: assert property (@(posedge aclk) disable iff (!aresetn) //RL10
      freeze_mode && scr1[cct_pkg::SCR1_FRZ_STOP] && !test_mode |=> $stable(main_count))
      else $error("count moved in freeze");
   a_capture_val: assert property (@(posedge aclk) disable iff (!aresetn) //RL3
      cap[2] |=> ch_val[2] == $past(main_count) && ch_flags[2])
      else $error("capture did not record count");
   a_force_zero: assert property (@(posedge aclk) disable iff (!aresetn) //RL18
      rd_go && rd_idx == cct_pkg::IDX_FORCE |=> s_axi_rdata == 32'h00000000)
      else $error("force register read nonzero");
   a_force_noflag: assert property (@(posedge aclk) disable iff (!aresetn) //RL18
      force_ch[0] && !ch_flags[0] && !(flag_wr) |=> !ch_flags[0])
      else $error("forced compare set a flag");
   a_c7_override: assert property (@(posedge aclk) disable iff (!aresetn) //RL19
      c7_event && c7_mask[1] && !force_ch[1] |=> pin_q[1] == $past(c7_data[1]))
      else $error("channel 7 event not applied");
   a_mode_drive: assert property (@(posedge aclk) disable iff (!aresetn) //RL13
      wr_b0 && wr_idx == cct_pkg::IDX_MODE_SEL && !pin_disc[3] |=> ioc_oe[3] == $past(w_data[3]))
      else $error("mode write did not reach pin enable");
   a_cnt_no_write: assert property (@(posedge aclk) disable iff (!aresetn) //RL17
      !test_mode && !tick ##1 !test_mode |-> $stable(main_count))
      else $error("count changed without tick");
endmodule

// ### include/cct_pkg.sv
// constants shared by the capture/compare timer
package cct_pkg;
   localparam int IDX_W = 6;
   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_MODE_SEL = 6'h00;
   localparam logic [5:0] IDX_FORCE = 6'h01;
   localparam logic [5:0] IDX_C7_MASK = 6'h02;
   localparam logic [5:0] IDX_C7_DATA = 6'h03;
   localparam logic [5:0] IDX_CNT_HI = 6'h04;
   localparam logic [5:0] IDX_CNT_LO = 6'h05;
   localparam logic [5:0] IDX_SCR1 = 6'h06;
   localparam logic [5:0] IDX_TOV = 6'h07;
   localparam logic [5:0] IDX_ACT_UP = 6'h08;
   localparam logic [5:0] IDX_ACT_LO = 6'h09;
   localparam logic [5:0] IDX_EDGE_UP = 6'h0a;
   localparam logic [5:0] IDX_EDGE_LO = 6'h0b;
   localparam logic [5:0] IDX_IRQ_EN = 6'h0c;
   localparam logic [5:0] IDX_SCR2 = 6'h0d;
   localparam logic [5:0] IDX_CH_FLAGS = 6'h0e;
   localparam logic [5:0] IDX_OVF_FLAG = 6'h0f;
   localparam logic [5:0] IDX_CH_VAL = 6'h10;
   localparam logic [5:0] IDX_CH_VAL_END = 6'h1f;
   localparam logic [5:0] IDX_ACC_CTL = 6'h20;
   localparam logic [5:0] IDX_ACC_FLAGS = 6'h21;
   localparam logic [5:0] IDX_ACC_HI = 6'h22;
   localparam logic [5:0] IDX_ACC_LO = 6'h23;
   localparam logic [5:0] IDX_PIN_DISC = 6'h2c;
   localparam logic [5:0] IDX_PRE_SEL = 6'h2e;
   // system control one fields
   localparam int SCR1_RUN = 7;
   localparam int SCR1_WAIT_STOP = 6;
   localparam int SCR1_FRZ_STOP = 5;
   localparam int SCR1_FAST_CLR = 4;
   localparam int SCR1_PRECISE = 3;
   localparam logic [7:0] SCR1_MASK = 8'hf8;
   // system control two fields
   localparam int SCR2_RST_ON_C7 = 3;
   localparam logic [7:0] SCR2_MASK = 8'h8f;
   // accumulator control fields
   localparam int ACC_EN = 6;
   localparam int ACC_GATED = 5;
   localparam int ACC_EDGE = 4;
   localparam logic [7:0] ACC_CTL_MASK = 8'h7f;
   localparam int OVF_FLAG_BIT = 7;
   localparam int ACC_OVF_BIT = 1;
   localparam int ACC_EDGE_BIT = 0;
   // gated accumulator time base: bus clock divided by this
   localparam int GATE_DIV = 64;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // output actions and edge selects (two bits each)
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam logic [1:0] EDG_OFF = 2'h0;
   localparam logic [1:0] EDG_RISE = 2'h1;
   localparam logic [1:0] EDG_FALL = 2'h2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ### testbench/cct_pin_model.sv
// far-side model of the eight capture/compare pins
`timescale 1ns/1ps
module cct_pin_model (
   input wire logic [7:0] ioc_out, // design drive value
   input wire logic [7:0] ioc_oe, // design drive enable
   input wire logic [7:0] ext_level, // far-side level
   output logic [7:0] ioc_in // resolved pin level
);
   // design wins where it drives, far side elsewhere
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ioc_in[i] = ioc_oe[i] ? ioc_out[i] : ext_level[i];
      end
   end
endmodule

// ### testbench/cct_timer_tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module cct_timer_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic test_mode, wait_mode, freeze_mode;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, a;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [7:0] ioc_in, ioc_out, ioc_oe, ext_level;
   int n_errors, n_checks;
   cct_timer cct_timer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .test_mode,
      .wait_mode, .freeze_mode, .ioc_in, .ioc_out, .ioc_oe);
   cct_pin_model cct_pin_model_i (.ioc_out, .ioc_oe, .ext_level, .ioc_in);
   // ****************
   // bus tasks
   // ****************
   task automatic wr(input logic [5:0] idx, input logic [15:0] v);
      s_axi_awaddr <= {24'h0, idx, 2'h0};
      s_axi_wdata <= {16'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask
   task automatic rd(input logic [5:0] idx);
      s_axi_araddr <= {24'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // set control and modes, then see whether the count moves
   task automatic run_chk(input logic [7:0] scr, input logic w, input logic f, input logic run);
      wait_mode <= w;
      freeze_mode <= f;
      wr(6'h06, {8'h0, scr});
      rd(6'h04);
      a = d;
      rd(6'h04);
      chk({31'h0, d !== a}, {31'h0, run});
   endtask
   // ****************
   // tests
   // ****************
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      end_of_test();
   end
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, test_mode, wait_mode, freeze_mode} = 6'h0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      ext_level = 8'h00;
      n_errors = 0;
      n_checks = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(6'h00);
      chk(d, 32'h0);
      wr(6'h00, 16'h00a5);
      rd(6'h00);
      chk(d, 32'ha5);
      wr(6'h00, 16'h0000);
      rd(6'h01);
      chk(d, 32'h0);
      run_chk(8'h80, 1'b0, 1'b0, 1'b1);
      run_chk(8'h00, 1'b0, 1'b0, 1'b0);
      run_chk(8'ha0, 1'b0, 1'b1, 1'b0);
      run_chk(8'h80, 1'b0, 1'b1, 1'b1);
      run_chk(8'hc0, 1'b1, 1'b0, 1'b0);
      run_chk(8'h80, 1'b1, 1'b0, 1'b1);
      run_chk(8'h00, 1'b0, 1'b0, 1'b0);
      a = d;
      wr(6'h04, 16'h1234);
      rd(6'h04);
      chk(d, a);
      test_mode <= 1'b1;
      wr(6'h04, 16'h0010);
      rd(6'h04);
      chk(d, 32'h10);
      wr(6'h00, 16'h0003);
      wr(6'h09, 16'h000f);
      wr(6'h12, 16'h0030);
      wr(6'h01, 16'h0001);
      chk({24'h0, ioc_out}, 32'h1);
      chk({24'h0, ioc_oe}, 32'h3);
      rd(6'h0e);
      chk(d, 32'h0);
      wr(6'h06, 16'h0080);
      repeat (64) @(posedge aclk);
      chk({24'h0, ioc_out}, 32'h3);
      rd(6'h0e);
      chk(d, 32'h2);
      wr(6'h06, 16'h0000);
      wr(6'h04, 16'h4321);
      wr(6'h0b, 16'h0010);
      ext_level <= 8'h04;
      repeat (8) @(posedge aclk);
      rd(6'h14);
      chk(d, 32'h4321);
      rd(6'h0e);
      chk(d, 32'h6);
      wr(6'h20, 16'h0050);
      repeat (3) begin
         ext_level <= 8'h84;
         repeat (6) @(posedge aclk);
         ext_level <= 8'h04;
         repeat (6) @(posedge aclk);
      end
      rd(6'h22);
      chk(d, 32'h3);
      wr(6'h1e, 16'h4330);
      wr(6'h02, 16'h0002);
      wr(6'h00, 16'h0083);
      wr(6'h06, 16'h0080);
      repeat (32) @(posedge aclk);
      chk({24'h0, ioc_out}, 32'h1);
      rd(6'h24);
      chk({d[29:0], resp}, {30'h0, cct_pkg::AXI_SLVERR});
      wr(6'h24, 16'h00ff);
      chk({30'h0, resp}, {30'h0, cct_pkg::AXI_SLVERR});
      end_of_test();
   end
endmodule
